// ===== core/mac_tx_pkg.sv
/*
 * Constants and types for the transmit packet buffer and pause generator.
 * Assumes a single 32-bit AHB-Lite master path and one system clock.
 */
package mac_tx_pkg;
	localparam int DEPTH = 64;
	localparam int PTR_W = 7;
	localparam logic [6:0] DEPTH_V = 7'h40;
	localparam logic [6:0] STAT_W32 = 7'h03;
	localparam logic [6:0] STAT_W64 = 7'h02;
	localparam logic [1:0] HT_IDLE = 2'h0;
	localparam logic [1:0] HT_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic [1:0] K_DATA = 2'h0;
	localparam logic [1:0] K_HEAD = 2'h1;
	localparam logic [1:0] K_PAD = 2'h2;
	localparam logic [1:0] K_END = 2'h3;
	localparam int ERR_BIT = 31;
	localparam logic [15:0] QUANT_RST = 16'hffff;
	localparam logic [47:0] PFC_DA = 48'h0180c2000001;
	localparam logic [15:0] PFC_TYPE = 16'h8808;
	localparam logic [15:0] PFC_OPC = 16'h0101;
	localparam logic [6:0] B_SA = 7'h06;
	localparam logic [6:0] B_TYPE = 7'h0c;
	localparam logic [6:0] B_OPC = 7'h0e;
	localparam logic [6:0] B_VEC = 7'h11;
	localparam logic [6:0] B_QF = 7'h12;
	localparam logic [6:0] B_PAD = 7'h22;
	localparam logic [6:0] B_FCS = 7'h3c;
	localparam logic [6:0] B_END = 7'h40;
	localparam logic [31:0] CRC_POLY = 32'hedb88320;
	typedef enum logic [2:0] {
		F_IDLE = 3'b000,
		F_ADDR = 3'b001,
		F_DATA = 3'b010,
		F_STAT = 3'b011,
		F_HALT = 3'b100
	} fetch_t;
endpackage : mac_tx_pkg

// ===== core/mac_tx_buffer.sv
/*
 * Transmit packet buffer with AHB fetch, ordered status and PFC generator.
 * Assumes descriptors are held until acknowledged and frames fit the buffer.
 */
`timescale 1ns/1ns
`default_nettype none
module mac_tx_buffer (
	// Clock and reset.
	input wire logic CORE_CLK_I,
	input wire logic NRST_I,
	// Frame descriptor and control.
	input wire logic FRAME_REQ_I,
	input wire logic [31:0] FRAME_ADDR_I,
	input wire logic [5:0] FRAME_WORDS_I,
	input wire logic DP64_I,
	input wire logic RESTART_I,
	output logic FRAME_ACK_O,
	output logic FETCH_HALTED_O,
	// AHB master read port.
	output logic [1:0] HTRANS_O,
	output logic [31:0] HADDR_O,
	output logic [2:0] HSIZE_O,
	output logic HWRITE_O,
	input wire logic [31:0] HRDATA_I,
	input wire logic HREADY_I,
	input wire logic HRESP_I,
	// MAC transmit side.
	output logic [31:0] TX_DATA_O,
	output logic TX_VALID_O,
	input wire logic TX_READY_I,
	output logic STAT_VALID_O,
	output logic STAT_ERR_O,
	output logic [5:0] STAT_LEN_O,
	output logic AHB_ERR_IRQ_O,
	// Priority pause generator.
	input wire logic PFC_TRIG_I,
	input wire logic [15:0] PFC_PAUSE_I,
	input wire logic QUANT_WR_I,
	input wire logic [15:0] QUANT_DATA_I,
	input wire logic [47:0] MAC_SA_I,
	output logic [7:0] PFC_BYTE_O,
	output logic PFC_VALID_O,
	input wire logic PFC_READY_I,
	output logic PAUSE_TX_IRQ_O,
	output logic PAUSE_STAT_INC_O
);
	////////////////////////////////////////////////////////////////////////
	logic [33:0] mem_r [mac_tx_pkg::DEPTH];
	mac_tx_pkg::fetch_t fetch_r, fetch_nxt;
	logic [6:0] wr_r, wr_nxt, start_r, start_nxt, commit_r, commit_nxt;
	logic [6:0] rd_r, rd_nxt, free_r, free_nxt;
	logic [31:0] addr_r, addr_nxt;
	logic [5:0] cnt_r, cnt_nxt, len_r, len_nxt;
	logic [6:0] sidx_r, sidx_nxt;
	logic err_r, err_nxt, ack_nxt;
	logic [1:0] htrans_nxt;
	logic halted_nxt;
	logic wr_en;
	logic [33:0] wr_data;
	logic [6:0] used, space, need, sw;

	assign HSIZE_O = mac_tx_pkg::HSIZE_WORD;
	assign HWRITE_O = 1'b0;
	assign used = wr_r - free_r;
	assign space = mac_tx_pkg::DEPTH_V - used;
	assign sw = DP64_I ? mac_tx_pkg::STAT_W64 : mac_tx_pkg::STAT_W32;
	assign need = {1'b0, FRAME_WORDS_I} + sw;

	always_comb begin
		fetch_nxt = fetch_r;
		wr_nxt = wr_r;
		start_nxt = start_r;
		commit_nxt = commit_r;
		addr_nxt = addr_r;
		cnt_nxt = cnt_r;
		len_nxt = len_r;
		sidx_nxt = sidx_r;
		err_nxt = err_r;
		ack_nxt = 1'b0;
		wr_en = 1'b0;
		wr_data = '0;
		unique case (fetch_r)
			mac_tx_pkg::F_IDLE: begin
				// Waiting here for space is what lets freed packets refill.
				if (FRAME_REQ_I && space >= need) begin
					ack_nxt = 1'b1;
					addr_nxt = FRAME_ADDR_I;
					cnt_nxt = FRAME_WORDS_I;
					len_nxt = FRAME_WORDS_I;
					start_nxt = wr_r;
					err_nxt = 1'b0;
					sidx_nxt = '0;
					fetch_nxt = mac_tx_pkg::F_ADDR;
				end
			end
			mac_tx_pkg::F_ADDR: begin
				if (HREADY_I) begin
					fetch_nxt = mac_tx_pkg::F_DATA;
				end
			end
			mac_tx_pkg::F_DATA: begin
				if (HRESP_I) begin
					wr_nxt = start_r;
					err_nxt = 1'b1;
					fetch_nxt = mac_tx_pkg::F_STAT;
				end else if (HREADY_I) begin
					wr_en = 1'b1;
					wr_data = {mac_tx_pkg::K_DATA, HRDATA_I};
					wr_nxt = wr_r + 7'h01;
					cnt_nxt = cnt_r - 6'h01;
					addr_nxt = addr_r + 32'h4;
					fetch_nxt = (cnt_r == 6'h01) ? mac_tx_pkg::F_STAT
						: mac_tx_pkg::F_ADDR;
				end
			end
			mac_tx_pkg::F_STAT: begin
				wr_en = 1'b1;
				wr_data = {mac_tx_pkg::K_PAD, 32'h0};
				if (sidx_r == '0) begin
					wr_data = {mac_tx_pkg::K_HEAD, err_r, 25'h0, len_r};
				end else if (sidx_r == sw - 7'h01) begin
					wr_data = {mac_tx_pkg::K_END, 32'h0};
				end
				wr_nxt = wr_r + 7'h01;
				sidx_nxt = sidx_r + 7'h01;
				if (sidx_r == sw - 7'h01) begin
					commit_nxt = wr_r + 7'h01;
					fetch_nxt = err_r ? mac_tx_pkg::F_HALT
						: mac_tx_pkg::F_IDLE;
				end
			end
			mac_tx_pkg::F_HALT: begin
				if (RESTART_I) begin
					fetch_nxt = mac_tx_pkg::F_IDLE;
				end
			end
			default: fetch_nxt = mac_tx_pkg::F_IDLE;
		endcase
		htrans_nxt = (fetch_nxt == mac_tx_pkg::F_ADDR) ?
			mac_tx_pkg::HT_NONSEQ : mac_tx_pkg::HT_IDLE;
		halted_nxt = (fetch_nxt == mac_tx_pkg::F_HALT);
	end

	always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			fetch_r <= mac_tx_pkg::F_IDLE;
			wr_r <= '0;
			start_r <= '0;
			commit_r <= '0;
			addr_r <= '0;
			cnt_r <= '0;
			len_r <= '0;
			sidx_r <= '0;
			err_r <= 1'b0;
			FRAME_ACK_O <= 1'b0;
			HTRANS_O <= mac_tx_pkg::HT_IDLE;
			HADDR_O <= '0;
			FETCH_HALTED_O <= 1'b0;
		end else begin
			fetch_r <= fetch_nxt;
			wr_r <= wr_nxt;
			start_r <= start_nxt;
			commit_r <= commit_nxt;
			addr_r <= addr_nxt;
			cnt_r <= cnt_nxt;
			len_r <= len_nxt;
			sidx_r <= sidx_nxt;
			err_r <= err_nxt;
			FRAME_ACK_O <= ack_nxt;
			HTRANS_O <= htrans_nxt;
			HADDR_O <= addr_nxt;
			FETCH_HALTED_O <= halted_nxt;
		end
	end

	// The storage carries no reset; only committed entries are ever read.
	always_ff @(posedge CORE_CLK_I) begin
		if (wr_en) begin
			mem_r[wr_r[5:0]] <= wr_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	logic [33:0] ent;
	logic take, txv_nxt, stv_nxt, ste_nxt, irq_nxt;
	logic [31:0] txd_nxt;
	logic [5:0] stl_nxt;

	assign ent = mem_r[rd_r[5:0]];
	// Any frame, a software-built pause frame too, drains the same way.
	assign take = (rd_r != commit_r) && (!TX_VALID_O || TX_READY_I);

	always_comb begin
		rd_nxt = rd_r;
		free_nxt = free_r;
		txv_nxt = TX_VALID_O && !TX_READY_I;
		txd_nxt = TX_DATA_O;
		stv_nxt = 1'b0;
		ste_nxt = STAT_ERR_O;
		stl_nxt = STAT_LEN_O;
		irq_nxt = 1'b0;
		if (take) begin
			rd_nxt = rd_r + 7'h01;
			if (ent[33:32] == mac_tx_pkg::K_DATA) begin
				txv_nxt = 1'b1;
				txd_nxt = ent[31:0];
			end else if (ent[33:32] == mac_tx_pkg::K_HEAD) begin
				stv_nxt = 1'b1;
				ste_nxt = ent[mac_tx_pkg::ERR_BIT];
				stl_nxt = ent[5:0];
				irq_nxt = ent[mac_tx_pkg::ERR_BIT];
			end else if (ent[33:32] == mac_tx_pkg::K_END) begin
				free_nxt = rd_r + 7'h01;
			end
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			rd_r <= '0;
			free_r <= '0;
			TX_VALID_O <= 1'b0;
			TX_DATA_O <= '0;
			STAT_VALID_O <= 1'b0;
			STAT_ERR_O <= 1'b0;
			STAT_LEN_O <= '0;
			AHB_ERR_IRQ_O <= 1'b0;
		end else begin
			rd_r <= rd_nxt;
			free_r <= free_nxt;
			TX_VALID_O <= txv_nxt;
			TX_DATA_O <= txd_nxt;
			STAT_VALID_O <= stv_nxt;
			STAT_ERR_O <= ste_nxt;
			STAT_LEN_O <= stl_nxt;
			AHB_ERR_IRQ_O <= irq_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	logic [15:0] quant_r, quant_nxt;
	logic [7:0] vec_r, vec_nxt, mask_r, mask_nxt;
	logic [6:0] pidx_r, pidx_nxt, qoff;
	logic [31:0] crc_r, crc_nxt;
	logic busy_r, busy_nxt, pv_nxt, done_nxt, adv;
	logic [7:0] pb_nxt, cur;
	logic [15:0] qf;

	function automatic logic [31:0] crc_step(input logic [31:0] c,
		input logic [7:0] d);
		logic [31:0] x;
		x = c ^ {24'h0, d};
		for (int i = 0; i < 8; i++) begin
			x = x[0] ? ((x >> 1) ^ mac_tx_pkg::CRC_POLY) : (x >> 1);
		end
		return x;
	endfunction : crc_step

	assign adv = busy_r && (!PFC_VALID_O || PFC_READY_I);
	assign qoff = pidx_r - mac_tx_pkg::B_QF;
	assign qf = mask_r[qoff[3:1]] ? 16'h0 : quant_r;

	always_comb begin
		cur = 8'h00;
		if (pidx_r < mac_tx_pkg::B_SA) begin
			cur = mac_tx_pkg::PFC_DA[8 * (5 - pidx_r[2:0]) +: 8];
		end else if (pidx_r < mac_tx_pkg::B_TYPE) begin
			cur = MAC_SA_I[8 * (11 - pidx_r[3:0]) +: 8];
		end else if (pidx_r < mac_tx_pkg::B_OPC) begin
			cur = pidx_r[0] ? mac_tx_pkg::PFC_TYPE[7:0]
				: mac_tx_pkg::PFC_TYPE[15:8];
		end else if (pidx_r < mac_tx_pkg::B_VEC - 7'h01) begin
			// The byte ahead of the vector is its zero upper half.
			cur = pidx_r[0] ? mac_tx_pkg::PFC_OPC[7:0]
				: mac_tx_pkg::PFC_OPC[15:8];
		end else if (pidx_r == mac_tx_pkg::B_VEC) begin
			cur = vec_r;
		end else if (pidx_r >= mac_tx_pkg::B_QF
			&& pidx_r < mac_tx_pkg::B_PAD) begin
			cur = qoff[0] ? qf[7:0] : qf[15:8];
		end else if (pidx_r >= mac_tx_pkg::B_FCS) begin
			cur = ~crc_r[8 * pidx_r[1:0] +: 8];
		end
	end

	always_comb begin
		quant_nxt = QUANT_WR_I ? QUANT_DATA_I : quant_r;
		vec_nxt = vec_r;
		mask_nxt = mask_r;
		pidx_nxt = pidx_r;
		crc_nxt = crc_r;
		busy_nxt = busy_r;
		pv_nxt = PFC_VALID_O && !PFC_READY_I;
		pb_nxt = PFC_BYTE_O;
		done_nxt = 1'b0;
		if (!busy_r && PFC_TRIG_I) begin
			busy_nxt = 1'b1;
			vec_nxt = PFC_PAUSE_I[7:0];
			mask_nxt = PFC_PAUSE_I[15:8];
			pidx_nxt = '0;
			crc_nxt = 32'hffffffff;
		end else if (adv && pidx_r == mac_tx_pkg::B_END) begin
			busy_nxt = 1'b0;
			done_nxt = 1'b1;
		end else if (adv) begin
			pv_nxt = 1'b1;
			pb_nxt = cur;
			pidx_nxt = pidx_r + 7'h01;
			if (pidx_r < mac_tx_pkg::B_FCS) begin
				crc_nxt = crc_step(crc_r, cur);
			end
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			quant_r <= mac_tx_pkg::QUANT_RST;
			vec_r <= '0;
			mask_r <= '0;
			pidx_r <= '0;
			crc_r <= '0;
			busy_r <= 1'b0;
			PFC_VALID_O <= 1'b0;
			PFC_BYTE_O <= '0;
			PAUSE_TX_IRQ_O <= 1'b0;
			PAUSE_STAT_INC_O <= 1'b0;
		end else begin
			quant_r <= quant_nxt;
			vec_r <= vec_nxt;
			mask_r <= mask_nxt;
			pidx_r <= pidx_nxt;
			crc_r <= crc_nxt;
			busy_r <= busy_nxt;
			PFC_VALID_O <= pv_nxt;
			PFC_BYTE_O <= pb_nxt;
			PAUSE_TX_IRQ_O <= done_nxt;
			PAUSE_STAT_INC_O <= done_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	logic qwr_seen_r;
	logic [6:0] sent_r;
	always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			qwr_seen_r <= 1'b0;
			sent_r <= '0;
		end else begin
			qwr_seen_r <= qwr_seen_r || QUANT_WR_I;
			if (!busy_r) begin
				sent_r <= '0;
			end else if (PFC_VALID_O && PFC_READY_I) begin
				sent_r <= sent_r + 7'h01;
			end
		end
	end

	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (!NRST_I);

	a_space_bound: assert property (used <= mac_tx_pkg::DEPTH_V)
		else $error("Buffer holds more than its depth.");
	a_halt_no_read: assert property (FETCH_HALTED_O |-> HTRANS_O == 2'h0)
		else $error("Read issued while fetching is halted.");
	a_err_drop: assert property ((fetch_r == mac_tx_pkg::F_DATA && HRESP_I)
		|=> wr_r == $past(start_r) && fetch_r == mac_tx_pkg::F_STAT)
		else $error("Errored packet data was not dropped.");
	a_err_irq: assert property (AHB_ERR_IRQ_O |-> STAT_VALID_O && STAT_ERR_O)
		else $error("Error interrupt without its status update.");
	a_stat_order: assert property (STAT_VALID_O |-> !TX_VALID_O)
		else $error("Status reported while frame data still pending.");
	a_quant_reset: assert property (!qwr_seen_r |-> quant_r == 16'hffff)
		else $error("Pause quantum lost its reset value.");
	a_pause_len: assert property (PAUSE_TX_IRQ_O |-> sent_r == 7'h40)
		else $error("Pause frame is not 64 bytes long.");
	a_pause_stat: assert property (PAUSE_TX_IRQ_O |-> PAUSE_STAT_INC_O
		&& !STAT_VALID_O) else $error("Pause frame touched other counters.");
	a_masked_zero: assert property ((adv && pidx_r >= 7'h12 && pidx_r < 7'h22
		&& mask_r[qoff[3:1]]) |=> PFC_BYTE_O == 8'h00)
		else $error("Masked priority quantum is not zero.");
	a_ack_fetch: assert property (FRAME_ACK_O |-> HTRANS_O == 2'h2)
		else $error("Acknowledged frame did not start a read.");

	c_ahb_error: cover property (AHB_ERR_IRQ_O);
	c_pause_done: cover property (PAUSE_TX_IRQ_O);
	c_good_frame: cover property (STAT_VALID_O && !STAT_ERR_O);
	c_buffer_full: cover property (FRAME_REQ_I && space < need);
endmodule : mac_tx_buffer
`default_nettype wire

// ===== verif/ahb_mem_model.sv
/*
 * AHB read-only memory model for the transmit buffer fetch port.
 * Assumes one master issuing single NONSEQ word reads.
 */
`timescale 1ns/1ns
`default_nettype none
module ahb_mem_model (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic nrst_i,
	// AHB request.
	input wire logic [1:0] htrans_i,
	input wire logic [31:0] haddr_i,
	// Test controls.
	input wire logic slow_i,
	input wire logic err_en_i,
	input wire logic [31:0] err_addr_i,
	// AHB response.
	output logic [31:0] hrdata_o,
	output logic hready_o,
	output logic hresp_o
);
	logic ph_r;
	logic wt_r;
	logic [31:0] a_r;
	logic [31:0] pat;
	assign pat = a_r ^ 32'h5a5a0000;
	// An error response spans two cycles, the first with ready low.
	assign hready_o = !ph_r || !wt_r;
	assign hresp_o = ph_r && err_en_i && a_r == err_addr_i;
	// Outside a finished data phase the bus shows the inverse value.
	assign hrdata_o = (ph_r && !wt_r) ? pat : ~pat;
	////////////////////////////////////////////////////////////
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ph_r <= 1'b0;
			wt_r <= 1'b0;
			a_r <= 32'h00000000;
		end else if (hready_o) begin
			ph_r <= htrans_i == mac_tx_pkg::HT_NONSEQ;
			a_r <= haddr_i;
			wt_r <= slow_i || (err_en_i && haddr_i == err_addr_i);
		end else begin
			wt_r <= 1'b0;
		end
	end
endmodule : ahb_mem_model
`default_nettype wire

// ===== verif/mac_tx_buffer_pfc_pause_tb_top.sv
/*
 * Self-checking bench for the transmit buffer and pause generator.
 * Assumes the AHB memory model answers every fetch of the design.
 */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin \
	errors++; $display("Error %s exp %h got %h", n, e, s); end end
module mac_tx_buffer_pfc_pause_tb_top;
	localparam logic [47:0] SRC_MAC = 48'h021122334455;
	logic clk, nrst, req, dp64, restart, rdy_en, stall, trig, qwr;
	logic slow, err_en, tx_ready, pfc_ready, ack, halted, hwrite;
	logic hready, hresp, txv, sv, se, aerr, pv, pirq, pinc;
	logic [31:0] faddr, err_addr, haddr, hrdata, txd;
	logic [15:0] pause, qdata;
	logic [5:0] fwords, slen;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [7:0] pbyte;
	logic [31:0] rxq[$], expq[$];
	logic [7:0] stq[$], exps[$], pq[$], eb[64];
	int errors, tests_run, cyc, nirq;
	mac_tx_buffer dut (.CORE_CLK_I(clk), .NRST_I(nrst),
		.FRAME_REQ_I(req), .FRAME_ADDR_I(faddr), .FRAME_WORDS_I(fwords),
		.DP64_I(dp64), .RESTART_I(restart), .FRAME_ACK_O(ack),
		.FETCH_HALTED_O(halted), .HTRANS_O(htrans), .HADDR_O(haddr),
		.HSIZE_O(hsize), .HWRITE_O(hwrite), .HRDATA_I(hrdata),
		.HREADY_I(hready), .HRESP_I(hresp), .TX_DATA_O(txd),
		.TX_VALID_O(txv), .TX_READY_I(tx_ready), .STAT_VALID_O(sv),
		.STAT_ERR_O(se), .STAT_LEN_O(slen), .AHB_ERR_IRQ_O(aerr),
		.PFC_TRIG_I(trig), .PFC_PAUSE_I(pause), .QUANT_WR_I(qwr),
		.QUANT_DATA_I(qdata), .MAC_SA_I(SRC_MAC),
		.PFC_BYTE_O(pbyte), .PFC_VALID_O(pv), .PFC_READY_I(pfc_ready),
		.PAUSE_TX_IRQ_O(pirq), .PAUSE_STAT_INC_O(pinc));
	ahb_mem_model mem (.clk_i(clk), .nrst_i(nrst), .htrans_i(htrans),
		.haddr_i(haddr), .slow_i(slow), .err_en_i(err_en),
		.err_addr_i(err_addr), .hrdata_o(hrdata), .hready_o(hready),
		.hresp_o(hresp));
	////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		#1;
		cyc++;
		tx_ready = rdy_en && !(stall && cyc[0]);
		pfc_ready = !(stall && cyc[1]);
	end
	always @(posedge clk) begin
		if (txv && tx_ready) rxq.push_back(txd);
		if (sv) begin
			stq.push_back({aerr, se, slen});
			`CHK("stat_gap", 1'b0, txv)
		end
		if (pv && pfc_ready) pq.push_back(pbyte);
		if (pirq || pinc) begin
			nirq++;
			`CHK("pause_inc", pirq, pinc)
		end
	end
	task end_sim;
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : end_sim
	task tick;
		@(posedge clk);
		#1;
	endtask : tick
	task automatic frame(input logic [31:0] a, input logic [5:0] n,
		input bit bad);
		// One edge passes so a request never follows its own release.
		tick;
		faddr = a;
		fwords = n;
		req = 1'b1;
		for (int i = 0; i < n; i++) begin
			if (!bad) expq.push_back((a + 4 * i) ^ 32'h5a5a0000);
		end
		exps.push_back(bad ? 8'hc0 : {2'b00, n});
	endtask : frame
	task automatic wait_ack(input int lim, input bit exp);
		bit got;
		got = 1'b0;
		for (int i = 0; i < lim && !got; i++) begin
			tick;
			if (ack === 1'b1) begin
				got = 1'b1;
				`CHK("htrans", mac_tx_pkg::HT_NONSEQ, htrans)
				`CHK("haddr", faddr, haddr)
				req = 1'b0;
			end
		end
		`CHK("ack", exp, got)
	endtask : wait_ack
	// Status words arrive after their data, so status completion is awaited.
	task automatic drain;
		logic [7:0] e;
		for (int i = 0; i < 3000 && stq.size() < exps.size(); i++) tick;
		if (stq.size() < exps.size()) begin
			errors++;
			end_sim;
		end
		while (exps.size() > 0) begin
			e = exps.pop_front();
			if (e[7]) `CHK("stat_err", e[7:6], stq[0][7:6])
			else `CHK("stat", e, stq[0])
			stq.delete(0);
		end
		while (expq.size() > 0) begin
			`CHK("word", expq[0], rxq[0])
			expq.delete(0);
			rxq.delete(0);
		end
		`CHK("extra", 0, rxq.size())
	endtask : drain
	function automatic logic [31:0] crc(input int n);
		logic [31:0] c;
		c = 32'hffffffff;
		for (int i = 0; i < n; i++) begin
			c ^= {24'h000000, eb[i]};
			for (int k = 0; k < 8; k++) begin
				c = c[0] ? (c >> 1) ^ mac_tx_pkg::CRC_POLY : c >> 1;
			end
		end
		return ~c;
	endfunction : crc
	task automatic pfc(input logic [15:0] p, input logic [15:0] q);
		int n0, s0;
		logic [31:0] f;
		n0 = nirq;
		s0 = stq.size();
		pq.delete();
		for (int i = 0; i < 64; i++) eb[i] = 8'h00;
		for (int i = 0; i < 6; i++) begin
			eb[i] = mac_tx_pkg::PFC_DA[47 - 8 * i -: 8];
			eb[6 + i] = SRC_MAC[47 - 8 * i -: 8];
		end
		eb[12] = 8'h88;
		eb[13] = 8'h08;
		eb[14] = 8'h01;
		eb[15] = 8'h01;
		eb[17] = p[7:0];
		for (int i = 0; i < 8; i++) begin
			eb[18 + 2 * i] = p[8 + i] ? 8'h00 : q[15:8];
			eb[19 + 2 * i] = p[8 + i] ? 8'h00 : q[7:0];
		end
		f = crc(60);
		for (int j = 0; j < 4; j++) eb[60 + j] = f[8 * j +: 8];
		pause = p;
		trig = 1'b1;
		tick;
		trig = 1'b0;
		for (int i = 0; i < 1000 && nirq == n0; i++) tick;
		repeat (3) tick;
		`CHK("pause_irq", n0 + 1, nirq)
		`CHK("stat_none", s0, stq.size())
		`CHK("pfc_len", 64, pq.size())
		for (int i = 0; i < 64; i++) `CHK("pfc_byte", eb[i], pq[i])
	endtask : pfc
	////////////////////////////////////////////////////////////
	initial begin
		{nrst, req, dp64, restart, rdy_en, stall, trig, qwr} = 8'h00;
		{slow, err_en, tx_ready, pfc_ready} = 4'h0;
		{faddr, err_addr, fwords, pause, qdata} = 102'h0;
		repeat (10) @(posedge clk);
		#1;
		nrst = 1'b1;
		`CHK("hsize", mac_tx_pkg::HSIZE_WORD, hsize)
		`CHK("idle", 4'h0, {hwrite, htrans, ack})
		rdy_en = 1'b1;
		frame(32'h00000100, 6'h05, 1'b0);
		wait_ack(50, 1'b1);
		drain;
		slow = 1'b1;
		stall = 1'b1;
		for (int d = 1; d >= 0; d--) begin
			dp64 = d[0];
			rdy_en = 1'b0;
			frame(32'h00001000, 6'h3b, 1'b0);
			wait_ack(50, 1'b1);
			frame(32'h00002000, 6'h01, 1'b0);
			wait_ack(400, d[0]);
			if (d == 1) begin
				frame(32'h00003000, 6'h01, 1'b0);
				wait_ack(300, 1'b0);
			end
			rdy_en = 1'b1;
			wait_ack(1000, 1'b1);
			drain;
		end
		{slow, stall, rdy_en, err_en} = 4'h1;
		err_addr = 32'h00004004;
		frame(32'h00000500, 6'h04, 1'b0);
		wait_ack(50, 1'b1);
		frame(32'h00004000, 6'h04, 1'b1);
		wait_ack(100, 1'b1);
		for (int i = 0; i < 100 && halted !== 1'b1; i++) tick;
		`CHK("halted", 1'b1, halted)
		rdy_en = 1'b1;
		frame(32'h00000600, 6'h02, 1'b0);
		wait_ack(100, 1'b0);
		err_en = 1'b0;
		restart = 1'b1;
		tick;
		restart = 1'b0;
		wait_ack(100, 1'b1);
		drain;
		pfc(16'h00a5, 16'hffff);
		qdata = 16'h1234;
		qwr = 1'b1;
		tick;
		qwr = 1'b0;
		stall = 1'b1;
		pfc(16'h0f3c, 16'h1234);
		frame(32'h00000700, 6'h10, 1'b0);
		wait_ack(50, 1'b1);
		drain;
		`CHK("sw_pause", 2, nirq)
		end_sim;
	end
endmodule : mac_tx_buffer_pfc_pause_tb_top
`default_nettype wire
